// ---- shared/kms_pkg.sv ----
/*
  kms_pkg: register map, field layout, timing constants and state types
  of the keypad matrix scanner.
  Assumes a 25 MHz system clock; millisecond waits count prescaler ticks.
*/
`default_nettype none

package kms_pkg;

  // ----------------------------------------------------------------
  // register map and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CFG_OFS  = 8'h08;
  localparam logic [7:0] REG_STAT_OFS = 8'h10;
  localparam logic [7:0] CFG_RST      = 8'h10;  // filter on, rest zero
  localparam int CFG_ACI_LSB  = 5;
  localparam int CFG_DE_BIT   = 4;
  localparam int CFG_SD_BIT   = 3;
  localparam int CFG_LE_BIT   = 2;
  localparam int CFG_LT_LSB   = 0;
  localparam int STAT_MORE_BIT  = 7;
  localparam int STAT_PRESS_BIT = 6;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int SYS_CLK_NS = 40;
  localparam int GLITCH_NS  = 100;
  localparam int FILT_CYC   = (GLITCH_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int SETTLE_CYC = 8;  // sync plus filter latency after a row change
  localparam int PRE_W      = 16;
  localparam int MS_W       = 12;
  localparam logic [MS_W-1:0] DB1_SLOW_MS = 12'h006;
  localparam logic [MS_W-1:0] DB2_SLOW_MS = 12'h008;
  localparam logic [MS_W-1:0] DB1_FAST_MS = 12'h003;
  localparam logic [MS_W-1:0] DB2_FAST_MS = 12'h004;
  localparam logic [MS_W-1:0] ACLR_A_MS   = 12'h005;
  localparam logic [MS_W-1:0] ACLR_B_MS   = 12'h00a;
  localparam logic [MS_W-1:0] LP_0_MS     = 12'h014;
  localparam logic [MS_W-1:0] LP_1_MS     = 12'h028;
  localparam logic [MS_W-1:0] LP_2_MS     = 12'h3e8;
  localparam logic [MS_W-1:0] LP_3_MS     = 12'h7d0;

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {SC_IDLE, SC_SCAN, SC_WAIT, SC_IRQ, SC_LPWAIT} kms_scan_st_t;
  typedef enum logic [3:0] {LK_IDLE, LK_ADDR, LK_ACKA, LK_WREG, LK_ACKW, LK_WDATA,
                            LK_RDWAIT, LK_RDATA, LK_RACK} kms_link_st_t;

endpackage

`default_nettype wire

// ---- rtl/kms_i2c_link.sv ----
/*
  kms_i2c_link: two-wire serial slave on the link clock, oversampling
  the bus pins. Hands register writes and read requests to the system
  domain by toggles; pointer and data words stay stable around them.
  Assumes the link clock is at least ten times the bus clock.
*/
`default_nettype none

module kms_i2c_link import kms_pkg::*; #(
  parameter logic [6:0] I2C_ADDR = 7'h58
) (
  input  wire logic       i_link_clk,  // oversampling clock
  input  wire logic       i_rst,       // system reset, synced here
  input  wire logic       i_rst_n,     // bus reset pin, active low
  input  wire logic       i_scl,       // bus clock pin
  input  wire logic       i_sda,       // bus data pin level
  output logic            o_sda_oe,    // pull data line low
  output logic [7:0]      o_ptr,       // register pointer
  output logic            o_wr_tg,     // toggles per written byte
  output logic [7:0]      o_wr_data,   // written byte
  output logic            o_rd_tg,     // toggles per read request
  input  wire logic       i_rd_ack,    // answer toggle from system side
  input  wire logic [7:0] i_rd_data    // answer byte
);

  typedef struct packed {
    kms_link_st_t st;
    logic [1:0]   rs, rn, scl_s, sda_s, ack_s;
    logic         scl_p, sda_p, rw, mack, oe, wr_tg, rd_tg;
    logic [3:0]   cnt;
    logic [7:0]   sh, ptr, wr_data;
  } kms_link_state_t;

  localparam kms_link_state_t LINK_RST = '{st: LK_IDLE, rn: 2'h3, scl_s: 2'h3,
    sda_s: 2'h3, scl_p: 1'b1, sda_p: 1'b1, default: '0};

  kms_link_state_t q, d;
  logic scl, sda, rise, fall, start, stop;

  // ----------------------------------------------------------------
  // bus protocol
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.rs    = {q.rs[0], i_rst};
    d.rn    = {q.rn[0], i_rst_n};
    d.scl_s = {q.scl_s[0], i_scl};
    d.sda_s = {q.sda_s[0], i_sda};
    d.ack_s = {q.ack_s[0], i_rd_ack};
    d.scl_p = q.scl_s[1];
    d.sda_p = q.sda_s[1];
    scl   = q.scl_s[1];
    sda   = q.sda_s[1];
    rise  = scl & ~q.scl_p;
    fall  = ~scl & q.scl_p;
    start = scl & q.scl_p & q.sda_p & ~sda;
    stop  = scl & q.scl_p & ~q.sda_p & sda;
    if (!q.rn[1] || stop) begin
      d.st = LK_IDLE;
      d.oe = 1'b0;
    end else if (start) begin
      d.st  = LK_ADDR;
      d.cnt = 4'h0;
      d.oe  = 1'b0;
    end else begin
      if (rise && (q.st == LK_ADDR || q.st == LK_WREG || q.st == LK_WDATA)) begin
        d.sh  = {q.sh[6:0], sda};
        d.cnt = q.cnt + 4'h1;
      end
      if (rise && q.st == LK_RACK) begin
        d.mack = ~sda;
      end
      unique case (q.st)
        LK_IDLE: ;
        LK_ADDR: if (fall && q.cnt == 4'h8) begin
          if (q.sh[7:1] == I2C_ADDR) begin
            d.rw = q.sh[0];
            d.oe = 1'b1;
            d.st = LK_ACKA;
          end else begin
            d.st = LK_IDLE;
          end
        end
        LK_ACKA: if (fall) begin
          d.oe  = 1'b0;
          d.cnt = 4'h0;
          if (q.rw) begin
            d.rd_tg = ~q.rd_tg;
            d.st    = LK_RDWAIT;
          end else begin
            d.st = LK_WREG;
          end
        end
        LK_WREG: if (fall && q.cnt == 4'h8) begin
          d.ptr = q.sh;
          d.oe  = 1'b1;
          d.st  = LK_ACKW;
        end
        LK_ACKW: if (fall) begin
          d.oe  = 1'b0;
          d.cnt = 4'h0;
          d.st  = LK_WDATA;
        end
        LK_WDATA: if (fall && q.cnt == 4'h8) begin
          d.wr_data = q.sh;
          d.wr_tg   = ~q.wr_tg;
          d.oe      = 1'b1;
          d.st      = LK_ACKW;
        end
        // answer lands while the bus clock is still low
        LK_RDWAIT: if (q.ack_s[1] == q.rd_tg) begin
          d.sh  = i_rd_data;
          d.oe  = ~i_rd_data[7];
          d.cnt = 4'h0;
          d.st  = LK_RDATA;
        end
        LK_RDATA: if (fall) begin
          if (q.cnt == 4'h7) begin
            d.oe   = 1'b0;
            d.mack = 1'b0;
            d.st   = LK_RACK;
          end else begin
            d.sh  = {q.sh[6:0], 1'b0};
            d.oe  = ~q.sh[6];
            d.cnt = q.cnt + 4'h1;
          end
        end
        LK_RACK: if (fall) begin
          if (q.mack) begin
            d.rd_tg = ~q.rd_tg;
            d.st    = LK_RDWAIT;
          end else begin
            d.st = LK_IDLE;
          end
        end
      endcase
    end
  end

  // reset sync keeps shifting under reset so release is seen
  always_ff @(posedge i_link_clk) begin
    q <= d;
    if (q.rs[1]) begin
      q    <= LINK_RST;
      q.rs <= d.rs;
    end
  end

  assign o_sda_oe  = q.oe;
  assign o_ptr     = q.ptr;
  assign o_wr_tg   = q.wr_tg;
  assign o_wr_data = q.wr_data;
  assign o_rd_tg   = q.rd_tg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb_link @(posedge i_link_clk); endclocking
  default disable iff (q.rs[1]);

  chk_bus_reset_idle: assert property (!q.rn[1] |=> q.st == LK_IDLE && !q.oe)
    else $error("bus reset did not return link to idle");
  chk_addr_ack_drive: assert property (q.st == LK_ACKA |-> q.oe && q.sh[7:1] == I2C_ADDR)
    else $error("address acknowledge not driven");

endmodule // kms_i2c_link

`default_nettype wire

// ---- rtl/kms_keypad_scanner.sv ----
/*
  kms_keypad_scanner: 8x8 key matrix scanner with debounce, ordered
  event queue, interrupt, auto clear and long-press repeat.
  Assumes pulled-up sense lines, a free-running link clock for the
  serial slave, and a host that drains events while the interrupt is low.
*/
`default_nettype none

module kms_keypad_scanner import kms_pkg::*; #(
  parameter int unsigned CYC_PER_MS = SYS_CLK_HZ / 1000,
  parameter logic [6:0]  I2C_ADDR   = 7'h58
) (
  input  wire logic       i_sys_clk,            // system clock, 25 MHz
  input  wire logic       i_rst,                // sync reset, active high
  input  wire logic       i_link_clk,           // serial oversampling clock
  input  wire logic       i_rst_n,              // bus reset pin, active low
  input  wire logic       i_scl,                // bus clock pin
  input  wire logic       i_sda,                // bus data pin level
  output logic            o_sda_oe,             // pull data low when high
  output logic            o_sda_o,              // data drive level, always 0
  input  wire logic [7:0] i_column_sense_lines, // pulled-up sense columns
  output logic [7:0]      o_row_drive_lines,    // row drives
  output logic            o_int_n               // key event irq, active low
);

  typedef struct packed {
    kms_scan_st_t    st;
    logic [1:0]      scan_no;
    logic [2:0]      row;
    logic [3:0]      settle;
    logic [PRE_W-1:0] pre;
    logic [MS_W-1:0] ms;
    logic [63:0]     first, cur, prev, ev, kst;
    logic            mism, lp, irq, read_seen, rd_ack;
    logic [7:0]      cfg, col_s1, col_s2, filt, rd_data;
    logic [15:0]     fcnt;
    logic [2:0]      wr_sy, rd_sy;
  } kms_sys_state_t;

  localparam kms_sys_state_t SYS_RST = '{st: SC_IDLE, cfg: CFG_RST, col_s1: 8'hff,
    col_s2: 8'hff, filt: 8'hff, default: '0};

  kms_sys_state_t q, d;
  logic [7:0] ptr, wr_data, cols, expect_cols, colbits, keep;
  logic       wr_tg, rd_tg, rsp_fire, chg, aci_on;
  logic [5:0] idx;
  logic [MS_W-1:0] wait_ms, aci_ms, lp_ms;
  logic [63:0] res, evm;

  // ----------------------------------------------------------------
  // serial link on its own clock
  // ----------------------------------------------------------------
  kms_i2c_link #(.I2C_ADDR(I2C_ADDR)) u_link (
    .i_link_clk (i_link_clk),
    .i_rst      (i_rst),
    .i_rst_n    (i_rst_n),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .o_sda_oe   (o_sda_oe),
    .o_ptr      (ptr),
    .o_wr_tg    (wr_tg),
    .o_wr_data  (wr_data),
    .o_rd_tg    (rd_tg),
    .i_rd_ack   (q.rd_ack),
    .i_rd_data  (q.rd_data)
  );

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  always_comb begin
    aci_on = 1'b1;
    unique case (q.cfg[CFG_ACI_LSB +: 2])
      2'h1:    aci_ms = ACLR_A_MS;
      2'h2:    aci_ms = ACLR_B_MS;
      default: begin
        aci_ms = ACLR_B_MS;
        aci_on = 1'b0;               // 00 off, 11 treated as off
      end
    endcase
    unique case (q.cfg[CFG_LT_LSB +: 2])
      2'h0: lp_ms = LP_0_MS;
      2'h1: lp_ms = LP_1_MS;
      2'h2: lp_ms = LP_2_MS;
      2'h3: lp_ms = LP_3_MS;
    endcase
    if (q.cfg[CFG_SD_BIT]) begin
      wait_ms = (q.scan_no == 2'h1) ? DB1_FAST_MS : DB2_FAST_MS;
    end else begin
      wait_ms = (q.scan_no == 2'h1) ? DB1_SLOW_MS : DB2_SLOW_MS;
    end
  end

  // lowest pending code is served first
  always_comb begin
    idx = 6'h00;
    for (int i = 63; i >= 0; i--) begin
      if (q.ev[i]) idx = 6'(i);
    end
  end

  assign cols     = q.cfg[CFG_DE_BIT] ? q.filt : q.col_s2;
  assign rsp_fire = q.rd_sy[2] != q.rd_sy[1];

  // ----------------------------------------------------------------
  // main next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    res = 64'h0;
    evm = 64'h0;
    colbits = 8'h00;
    keep = 8'h00;
    d.col_s1 = i_column_sense_lines;
    d.col_s2 = q.col_s1;
    d.wr_sy  = {q.wr_sy[1:0], wr_tg};
    d.rd_sy  = {q.rd_sy[1:0], rd_tg};
    // glitch filter: a column change must hold FILT_CYC cycles
    for (int c = 0; c < 8; c++) begin
      expect_cols[c] = ~|q.prev[c*8 +: 8];
      if (q.col_s2[c] == q.filt[c]) begin
        d.fcnt[2*c +: 2] = 2'h0;
      end else if (q.fcnt[2*c +: 2] == 2'(FILT_CYC - 1)) begin
        d.filt[c] = q.col_s2[c];
        d.fcnt[2*c +: 2] = 2'h0;
      end else begin
        d.fcnt[2*c +: 2] = q.fcnt[2*c +: 2] + 2'h1;
      end
    end
    chg = cols != expect_cols;
    // millisecond prescaler, restarted on each timed phase
    d.pre = q.pre + PRE_W'(1);
    if (q.pre == PRE_W'(CYC_PER_MS - 1)) begin
      d.pre = '0;
      d.ms  = q.ms + MS_W'(1);
    end
    // register write from the link; data stable around the toggle
    if (q.wr_sy[2] != q.wr_sy[1] && ptr == REG_CFG_OFS) begin
      d.cfg = wr_data;
    end
    // register read: status pops lowest event, any irq level
    if (rsp_fire) begin
      d.rd_ack  = ~q.rd_ack;
      d.rd_data = 8'h00;
      if (ptr == REG_CFG_OFS) begin
        d.rd_data = q.cfg;
      end else if (ptr == REG_STAT_OFS) begin
        d.read_seen = 1'b1;
        if (|q.ev) begin
          d.ev[idx] = 1'b0;
          d.rd_data = {|d.ev, q.kst[idx], idx};
        end
      end
    end
    unique case (q.st)
      SC_IDLE, SC_LPWAIT: begin
        if (chg || (q.st == SC_LPWAIT && q.ms == lp_ms)) begin
          d.st = SC_SCAN;
          d.lp = !chg;
          d.scan_no = 2'h0;
          d.row = 3'h0;
          d.settle = 4'h0;
          d.cur = 64'h0;
          d.mism = 1'b0;
        end
      end
      SC_WAIT: begin
        if (q.ms == wait_ms) begin
          d.st = SC_SCAN;
          d.row = 3'h0;
          d.settle = 4'h0;
          d.cur = 64'h0;
        end
      end
      SC_SCAN: begin
        if (q.settle != 4'(SETTLE_CYC - 1)) begin
          d.settle = q.settle + 4'h1;
        end else begin
          d.settle = 4'h0;
          for (int c = 0; c < 8; c++) begin
            if (!cols[c]) d.cur[c*8 + q.row] = 1'b1;
          end
          d.row = q.row + 3'h1;
          if (q.row == 3'h7) begin
            if (q.scan_no == 2'h0) begin
              d.first = d.cur;
            end else begin
              d.mism = q.mism | (d.cur != q.first);
            end
            if (q.scan_no != 2'h2) begin
              d.st = SC_WAIT;
              d.scan_no = q.scan_no + 2'h1;
              d.pre = '0;
              d.ms = '0;
            end else if (d.mism) begin
              d.st = SC_IDLE;
            end else begin
              // per column: keep a held key, else the lowest row seen
              for (int c = 0; c < 8; c++) begin
                colbits = d.cur[c*8 +: 8];
                keep = q.prev[c*8 +: 8] & colbits;
                res[c*8 +: 8] = (|keep) ? keep : (colbits & (~colbits + 8'h01));
              end
              evm = (res ^ q.prev) | (q.lp ? res : 64'h0);
              if (|evm) begin
                d.ev = evm;
                d.kst = res;
                d.prev = res;
                d.irq = 1'b1;
                d.read_seen = 1'b0;
                d.st = SC_IRQ;
                d.pre = '0;
                d.ms = '0;
              end else begin
                d.st = SC_IDLE;
              end
            end
          end
        end
      end
      SC_IRQ: begin
        // keypad changes are not looked at in this state
        if (d.ev == 64'h0 || (aci_on && !q.read_seen && q.ms == aci_ms)) begin
          d.irq = 1'b0;
          d.pre = '0;
          d.ms = '0;
          if (q.cfg[CFG_LE_BIT] && |q.prev) begin
            d.st = SC_LPWAIT;
          end else begin
            d.st = SC_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      q <= SYS_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // standby holds every row low; scan pulls one row low at a time
  assign o_row_drive_lines = (q.st == SC_SCAN) ? ~(8'h01 << q.row) : 8'h00;
  assign o_int_n = ~q.irq;
  assign o_sda_o = 1'b0;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb_sys @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence s_stat_pop;
    rsp_fire && ptr == REG_STAT_OFS && |q.ev && q.st != SC_SCAN;
  endsequence
  sequence s_last_pop;
    s_stat_pop ##0 (q.st == SC_IRQ && $onehot(q.ev));
  endsequence
  sequence s_auto_clr;
    q.st == SC_IRQ && aci_on && !q.read_seen && q.ms == aci_ms && !rsp_fire;
  endsequence

  chk_rows_standby: assert property (q.st != SC_SCAN |-> o_row_drive_lines == 8'h00)
    else $error("rows not all low outside scan");
  chk_code_order: assert property (s_stat_pop |=>
      (q.ev & ((64'h2 << q.rd_data[5:0]) - 64'h1)) == 64'h0)
    else $error("event returned out of code order");
  chk_more_flag: assert property (s_stat_pop |=> q.rd_data[7] == (|q.ev))
    else $error("more flag does not match pending events");
  chk_int_last_read: assert property (s_last_pop |=> o_int_n && q.ev == 64'h0)
    else $error("interrupt not released after last event");
  chk_no_scan_irq: assert property (q.irq |=> q.st != SC_SCAN)
    else $error("scan started while interrupt asserted");
  chk_auto_clear: assert property (s_auto_clr |=> o_int_n)
    else $error("auto clear did not release interrupt");
  chk_keep_events: assert property (s_auto_clr |=> q.ev == $past(q.ev))
    else $error("auto clear changed event registers");
  chk_latch_match: assert property ($rose(q.irq) |-> !q.mism && $past(q.scan_no) == 2'h2)
    else $error("events latched without three matching scans");
  chk_wait_length: assert property (q.st == SC_WAIT |=>
      (q.st == SC_SCAN) == ($past(q.ms) == $past(wait_ms)))
    else $error("debounce wait length wrong");

endmodule // kms_keypad_scanner

`default_nettype wire

// ---- bench/kms_host_model.sv ----
/*
  kms_host_model: two-wire bus master standing in for the host controller.
  Assumes the bench resolves the data wire with a pull-up; bit time 800 ns.
*/
`default_nettype none

module kms_host_model #(
  parameter logic [6:0] ADDR = 7'h58  // same as the device address
) (
  output logic      o_scl,     // bus clock, driven by master only
  output logic      o_sda_oe,  // pull data low when high
  input  wire logic i_sda      // resolved data wire
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end

  // one bit; data moves well after the clock falls, never while it is high
  task automatic bit_io(input logic b, output logic s);
    #100 o_sda_oe = ~b;
    #300 o_scl = 1'b1;
    #200 s = i_sda;
    #200 o_scl = 1'b0;
  endtask

  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // start condition, then address and direction
  task automatic open(input logic rd, output logic ack);
    #400 o_sda_oe = 1'b1;
    #400 o_scl = 1'b0;
    send({ADDR, rd}, ack);
  endtask

  task automatic close();
    #100 o_sda_oe = 1'b1;
    #300 o_scl = 1'b1;
    #400 o_sda_oe = 1'b0;
    #400;
  endtask

  task automatic write(input logic [7:0] ptr, input logic [7:0] d, input logic put,
                       output logic ok);
    logic a;
    open(1'b0, ok);
    send(ptr, a);
    ok &= a;
    if (put) begin
      send(d, a);
      ok &= a;
    end
    close();
  endtask

  // with drain set, keeps acking while the more flag is up
  task automatic read(input logic drain, output logic [7:0] q[$], output logic ok);
    logic [7:0] d;
    logic       s;
    logic       more;
    q = {};
    open(1'b1, ok);
    #1000;  // device fetches its first byte
    do begin
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      q.push_back(d);
      more = drain & d[7];
      bit_io(~more, s);
      if (more) #1000;
    end while (more);
    close();
  endtask
endmodule  // kms_host_model

`default_nettype wire

// ---- bench/kms_keypad_scanner_tb.sv ----
/*
  kms_keypad_scanner_tb: self-checking bench for the keypad scanner.
  Assumes a behavioural key matrix and the host model on the serial bus.
*/
`default_nettype none

module kms_keypad_scanner_tb import kms_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic       sys_clk  = 1'b0;
  logic       link_clk = 1'b0;
  logic       rst      = 1'b1;
  logic       rst_n    = 1'b1;
  logic       scl, host_oe, dev_oe, int_n;
  logic [7:0] rows, cols;
  logic [7:0] keys [8] = '{default: 8'h00};
  int         errors      = 0;
  int         check_count = 0;
  wire        sda = ~(host_oe | dev_oe);  // pulled up unless someone pulls

  always #20 sys_clk = ~sys_clk;
  always #16 link_clk = ~link_clk;

  // key matrix: a held key ties its column to its row drive
  always_comb begin
    for (int c = 0; c < 8; c++) cols[c] = ~|(keys[c] & ~rows);
  end

  kms_keypad_scanner #(.CYC_PER_MS(25)) i_kms_keypad_scanner (
    .i_sys_clk(sys_clk), .i_rst(rst), .i_link_clk(link_clk), .i_rst_n(rst_n),
    .i_scl(scl), .i_sda(sda), .o_sda_oe(dev_oe), .o_sda_o(),
    .i_column_sense_lines(cols), .o_row_drive_lines(rows), .o_int_n(int_n));

  kms_host_model i_kms_host_model (.o_scl(scl), .o_sda_oe(host_oe), .i_sda(sda));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_int(input logic lvl);
    check8({7'h00, int_n}, {7'h00, lvl});
  endtask

  // bounded wait for an interrupt level
  task automatic wait_int(input logic lvl);
    int n = 0;
    while (int_n !== lvl && n < 3000) begin
      tick();
      n++;
    end
    check_int(lvl);
  endtask

  // sets the pointer, reads and compares every byte
  task automatic read_chk(input logic [7:0] ptr, input logic drain, input logic [7:0] exp[$]);
    logic [7:0] q[$];
    logic       ok;
    i_kms_host_model.write(ptr, 8'h00, 1'b0, ok);
    i_kms_host_model.read(drain, q, ok);
    check8({7'h00, ok}, 8'h01);
    check8(8'(q.size()), 8'(exp.size()));
    foreach (exp[i]) check8(q[i], exp[i]);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check8(rows, 8'h00);
    check_int(1'b1);
    read_chk(REG_CFG_OFS, 1'b0, '{CFG_RST});
    read_chk(8'h20, 1'b0, '{8'h00});
    $display("test reset done");
  endtask

  task automatic t_single();
    keys[3][1] = 1'b1;
    tick(400);
    check_int(1'b1);
    wait_int(1'b0);
    read_chk(REG_STAT_OFS, 1'b1, '{8'h59});
    check_int(1'b1);
    keys[3][1] = 1'b0;
    wait_int(1'b0);
    read_chk(REG_STAT_OFS, 1'b1, '{8'h19});
    check8(rows, 8'h00);
    $display("test single done");
  endtask

  task automatic t_multi();
    keys[4][2] = 1'b1;
    keys[7][3] = 1'b1;
    keys[5][0] = 1'b1;
    keys[5][6] = 1'b1;
    wait_int(1'b0);
    read_chk(REG_STAT_OFS, 1'b1, '{8'he2, 8'he8, 8'h7b});
    keys = '{default: 8'h00};
    wait_int(1'b0);
    read_chk(REG_STAT_OFS, 1'b1, '{8'ha2, 8'ha8, 8'h3b});
    check_int(1'b1);
    $display("test multi done");
  endtask

  task automatic t_busrst();
    logic ok;
    keys[2][5] = 1'b1;
    wait_int(1'b0);
    i_kms_host_model.open(1'b0, ok);
    tick();
    rst_n = 1'b0;
    tick(8);
    check8({7'h00, dev_oe}, 8'h00);
    check_int(1'b0);
    rst_n = 1'b1;
    tick(8);
    i_kms_host_model.close();
    read_chk(REG_STAT_OFS, 1'b1, '{8'h55});
    keys[2][5] = 1'b0;
    wait_int(1'b0);
    read_chk(REG_STAT_OFS, 1'b1, '{8'h15});
    $display("test bus reset done");
  endtask

  task automatic t_auto();
    logic ok;
    i_kms_host_model.write(REG_CFG_OFS, 8'h30, 1'b1, ok);
    keys[1][0] = 1'b1;
    wait_int(1'b0);
    tick(115);
    check_int(1'b0);
    tick(20);
    check_int(1'b1);
    keys[1][0] = 1'b0;
    wait_int(1'b0);
    read_chk(REG_STAT_OFS, 1'b1, '{8'h08});
    $display("test auto clear done");
  endtask

  // fast debounce plus long-press repeat of a held key
  task automatic t_long();
    logic ok;
    i_kms_host_model.write(REG_CFG_OFS, 8'h1c, 1'b1, ok);
    check8({7'h00, ok}, 8'h01);
    keys[6][4] = 1'b1;
    tick(300);
    check_int(1'b1);
    tick(150);
    check_int(1'b0);
    read_chk(REG_STAT_OFS, 1'b1, '{8'h74});
    tick(300);
    check_int(1'b1);
    wait_int(1'b0);
    read_chk(REG_STAT_OFS, 1'b1, '{8'h74});
    keys[6][4] = 1'b0;
    wait_int(1'b0);
    read_chk(REG_STAT_OFS, 1'b1, '{8'h34});
    $display("test long press done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    tick(6);
    rst = 1'b0;
    tick(4);
    t_reset();
    t_single();
    t_multi();
    t_busrst();
    t_auto();
    t_long();
    tally_and_finish();
  end

  initial begin
    #3_000_000;
    errors++;
    tally_and_finish();
  end
endmodule  // kms_keypad_scanner_tb

`default_nettype wire
